// ==== rtl/tccm_channel.sv ====
// timer channel: command and mode registers, counter, capture and waveform output
//
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "tccm_cfg.svh"
module tccm_channel
#(
   parameter int CNT_W = 16
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [4:0] internal_clock_taps,
   input wire logic [2:0] ext_clock_in,
   input wire logic io_line_a_in,
   output logic io_line_a_out,
   output logic io_line_a_oe_n,
   input wire logic io_line_b_in,
   output logic io_line_b_out,
   output logic io_line_b_oe_n
);
   logic [31:0] mode_r;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] ra_r;
   logic [CNT_W-1:0] rb_r;
   logic [CNT_W-1:0] rc_r;
   logic [CNT_W-1:0] top;
   logic [CNT_W-1:0] step;
   logic [4:0] tap_prev_r;
   logic [7:0] src_rise;
   logic [7:0] src_fall;
   logic [3:0] gate_vec;
   logic clk_en_r, clk_stop_r, dir_r, dir_step, running, sel_edge, tick;
   logic wave, updown, evt_hit, ext_trig, sw_trig, c_trig, any_trig, flip_trig;
   logic zero_trig, a_match, b_match, c_match, a_load, b_load, stop_set, dis_hw;
   logic out_a_r, out_b_r, oe_a_n_r, oe_b_n_r, b_out_en;
   logic aw_full_r, w_full_r, bvalid_r, rvalid_r, wr_go, cmd_wr;
   logic [7:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic [1:0] bresp_r;
   logic [1:0] rresp_r;
   logic [31:0] rdata_r;
   logic [31:0] rd_mux;
   tccm_pkg::tccm_cap_type cap;
   tccm_pkg::tccm_wave_type wav;
   tccm_pkg::tccm_sig_type [4:0] pin_s;
   tccm_pkg::tccm_sig_type [2:0] xc;
   tccm_pkg::tccm_sig_type [3:0] evt_src;
   tccm_pkg::tccm_sig_type io_a;
   tccm_pkg::tccm_sig_type io_b;

   // ********************
   // helper functions
   // ********************
   function automatic logic edge_hit(input logic [1:0] sel, input tccm_pkg::tccm_sig_type s);
      edge_hit = (sel[0] & s.rise) | (sel[1] & s.fall);
   endfunction

   // hit and acts ordered {soft, event, c, own compare}; higher index wins
   function automatic logic resolve(input logic lvl, input logic [3:0] hit,
                                    input logic [7:0] acts);
      logic [1:0] act;
      act = 2'h0;
      for (int i = 0; i < 4; i++)
      begin
         if (hit[i])
            act = acts[2*i +: 2];
      end
      case (act)
         tccm_pkg::act_set: resolve = 1'h1;
         tccm_pkg::act_clear: resolve = 1'h0;
         tccm_pkg::act_toggle: resolve = ~lvl;
         default: resolve = lvl;
      endcase
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      for (int i = 0; i < 4; i++)
         merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
   endfunction

   function automatic logic addr_known(input logic [7:0] a);
      addr_known = (a == `TCCM_OFS_COMMAND) | (a == `TCCM_OFS_MODE) |
                   (a == `TCCM_OFS_COUNT) | (a == `TCCM_OFS_CMP_A) |
                   (a == `TCCM_OFS_CMP_B) | (a == `TCCM_OFS_CMP_C) |
                   (a == `TCCM_OFS_STATUS);
   endfunction

   // ********************
   // register bus slave
   // ********************
   assign awready = ~aw_full_r;
   assign wready = ~w_full_r;
   assign wr_go = aw_full_r & w_full_r & ~bvalid_r;
   assign cmd_wr = wr_go & (aw_addr_r == `TCCM_OFS_COMMAND) & w_strb_r[0];
   assign bvalid = bvalid_r;
   assign bresp = bresp_r;
   assign arready = ~rvalid_r;
   assign rvalid = rvalid_r;
   assign rresp = rresp_r;
   assign rdata = rdata_r;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_full_r <= 1'h0;
         w_full_r <= 1'h0;
         bvalid_r <= 1'h0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
         bresp_r <= `TCCM_RESP_OKAY;
      end
      else
      begin
         if (awvalid & ~aw_full_r)
         begin
            aw_full_r <= 1'h1;
            aw_addr_r <= awaddr;
         end
         else if (wr_go)
            aw_full_r <= 1'h0;
         if (wvalid & ~w_full_r)
         begin
            w_full_r <= 1'h1;
            w_data_r <= wdata;
            w_strb_r <= wstrb;
         end
         else if (wr_go)
            w_full_r <= 1'h0;
         if (wr_go)
         begin
            bvalid_r <= 1'h1;
            bresp_r <= addr_known(aw_addr_r) ? `TCCM_RESP_OKAY : `TCCM_RESP_SLVERR;
         end
         else if (bready)
            bvalid_r <= 1'h0;
      end
   end

   always_comb
   begin
      rd_mux = 32'h0000_0000;
      if (araddr == `TCCM_OFS_MODE)
         rd_mux = mode_r;
      else if (araddr == `TCCM_OFS_COUNT)
         rd_mux = 32'(cnt_r);
      else if (araddr == `TCCM_OFS_CMP_A)
         rd_mux = 32'(ra_r);
      else if (araddr == `TCCM_OFS_CMP_B)
         rd_mux = 32'(rb_r);
      else if (araddr == `TCCM_OFS_CMP_C)
         rd_mux = 32'(rc_r);
      else if (araddr == `TCCM_OFS_STATUS)
      begin
         rd_mux[`TCCM_STS_CLK_ON] = clk_en_r;
         rd_mux[`TCCM_STS_OUT_A] = out_a_r;
         rd_mux[`TCCM_STS_OUT_B] = out_b_r;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_r <= 1'h0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= `TCCM_RESP_OKAY;
      end
      else if (arvalid & ~rvalid_r)
      begin
         rvalid_r <= 1'h1;
         rdata_r <= rd_mux;
         rresp_r <= addr_known(araddr) ? `TCCM_RESP_OKAY : `TCCM_RESP_SLVERR;
      end
      else if (rready)
         rvalid_r <= 1'h0;
   end

   // ********************
   // mode and compare registers
   // ********************
   assign cap = tccm_pkg::tccm_cap_type'(mode_r);
   assign wav = tccm_pkg::tccm_wave_type'(mode_r);
   assign wave = cap.wave;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         mode_r <= `TCCM_MODE_RESET;
      else if (wr_go & (aw_addr_r == `TCCM_OFS_MODE))
         mode_r <= merge(mode_r, w_data_r, w_strb_r);
   end

   // capture loads win over a software write in the same cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ra_r <= '0;
         rb_r <= '0;
         rc_r <= '0;
      end
      else
      begin
         if (a_load)
            ra_r <= cnt_r;
         else if (wave & wr_go & (aw_addr_r == `TCCM_OFS_CMP_A))
            ra_r <= CNT_W'(merge(32'(ra_r), w_data_r, w_strb_r));
         if (b_load)
            rb_r <= cnt_r;
         else if (wave & wr_go & (aw_addr_r == `TCCM_OFS_CMP_B))
            rb_r <= CNT_W'(merge(32'(rb_r), w_data_r, w_strb_r));
         if (wr_go & (aw_addr_r == `TCCM_OFS_CMP_C))
            rc_r <= CNT_W'(merge(32'(rc_r), w_data_r, w_strb_r));
      end
   end

   // ********************
   // clock selection and gating
   // ********************
   tccm_pin_sync #(.W(5)) u_pin_sync
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_in({io_line_b_in, io_line_a_in, ext_clock_in}),
      .sig_out(pin_s)
   );
   assign xc = pin_s[2:0];
   assign io_a = pin_s[3];
   assign io_b = pin_s[4];

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         tap_prev_r <= 5'h00;
      else
         tap_prev_r <= internal_clock_taps;
   end

   assign src_rise = {xc[2].rise, xc[1].rise, xc[0].rise, internal_clock_taps & ~tap_prev_r};
   assign src_fall = {xc[2].fall, xc[1].fall, xc[0].fall, ~internal_clock_taps & tap_prev_r};
   assign gate_vec = {xc[2].lvl, xc[1].lvl, xc[0].lvl, 1'h1};
   assign sel_edge = cap.clock_invert ? src_fall[cap.clock_source_select]
                                      : src_rise[cap.clock_source_select];
   assign tick = sel_edge & gate_vec[cap.burst_gate] & running;

   // ********************
   // triggers and events
   // ********************
   assign evt_src = {xc[2], xc[1], xc[0], io_b};
   assign evt_hit = wave & edge_hit(wav.event_edge_select,
                                    evt_src[wav.event_source_select]);
   assign ext_trig = wave ? (evt_hit & wav.event_trigger_enable)
                          : edge_hit(cap.trigger_edge_select,
                                     cap.trigger_line_select ? io_a : io_b);
   assign sw_trig = cmd_wr & w_data_r[`TCCM_CMD_SW_TRIG];
   assign a_load = ~wave & edge_hit(cap.a_load_edge, io_a);
   assign b_load = ~wave & edge_hit(cap.b_load_edge, io_a);
   assign a_match = wave & tick & (step == ra_r);
   assign b_match = wave & tick & (step == rb_r);
   assign c_match = tick & (step == rc_r);
   assign c_trig = c_match & (wave ? (wav.waveform_select == 2'h2)
                                   : cap.c_match_trigger_enable);
   assign any_trig = sw_trig | ext_trig | c_trig;
   assign flip_trig = updown & (sw_trig | ext_trig);
   assign zero_trig = ~updown & any_trig;

   // ********************
   // clock enable and stop
   // ********************
   assign stop_set = (~wave & cap.stop_on_b_load & b_load) |
                     (wave & wav.stop_on_c_match & c_match);
   assign dis_hw = (~wave & cap.disable_on_b_load & b_load) |
                   (wave & wav.disable_on_c_match & c_match);
   assign running = clk_en_r & ~clk_stop_r;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         clk_en_r <= 1'h0;
      else if ((cmd_wr & w_data_r[`TCCM_CMD_CLK_DIS]) | dis_hw)
         clk_en_r <= 1'h0;
      else if (cmd_wr & w_data_r[`TCCM_CMD_CLK_EN])
         clk_en_r <= 1'h1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         clk_stop_r <= 1'h0;
      else if (stop_set)
         clk_stop_r <= 1'h1;
      else if (any_trig)
         clk_stop_r <= 1'h0;
   end

   // ********************
   // counter
   // ********************
   assign updown = wave & wav.waveform_select[0];
   assign top = wav.waveform_select[1] ? rc_r : {CNT_W{1'h1}};

   always_comb
   begin
      dir_step = dir_r;
      if (updown & ~dir_r & (cnt_r == top))
         dir_step = 1'h1;
      else if (updown & dir_r & (cnt_r == '0))
         dir_step = 1'h0;
      step = dir_step ? cnt_r - 1'h1 : cnt_r + 1'h1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         cnt_r <= '0;
      else if (zero_trig)
         cnt_r <= '0;
      else if (tick)
         cnt_r <= step;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         dir_r <= 1'h0;
      else if (~updown)
         dir_r <= 1'h0;
      else if (flip_trig)
         dir_r <= ~dir_r;
      else if (tick)
         dir_r <= dir_step;
   end

   // ********************
   // output lines
   // ********************
   assign b_out_en = wave & (wav.event_source_select != 2'h0);
   assign io_line_a_out = out_a_r;
   assign io_line_a_oe_n = oe_a_n_r;
   assign io_line_b_out = out_b_r;
   assign io_line_b_oe_n = oe_b_n_r;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         out_a_r <= 1'h0;
         out_b_r <= 1'h0;
         oe_a_n_r <= 1'h1;
         oe_b_n_r <= 1'h1;
      end
      else
      begin
         oe_a_n_r <= ~wave;
         oe_b_n_r <= ~b_out_en;
         if (wave)
            out_a_r <= resolve(out_a_r, {sw_trig, evt_hit, c_match, a_match},
                               {wav.out_a_on_soft_trigger, wav.out_a_on_event,
                                wav.out_a_on_c_match, wav.out_a_on_a_match});
         if (b_out_en)
            out_b_r <= resolve(out_b_r, {sw_trig, evt_hit, c_match, b_match},
                               {wav.out_b_on_soft_trigger, wav.out_b_on_event,
                                wav.out_b_on_c_match, wav.out_b_on_b_match});
      end
   end

   // ********************
   // assertions
   // ********************
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_enable_cmd;
      cmd_wr & w_data_r[`TCCM_CMD_CLK_EN] & ~w_data_r[`TCCM_CMD_CLK_DIS] & ~dis_hw;
   endsequence
   sequence s_c_restart;
      ~wave & cap.c_match_trigger_enable & c_match;
   endsequence
   sequence s_top_turn;
      updown & ~wav.waveform_select[1] & tick & ~dir_r & (cnt_r == {CNT_W{1'h1}}) & ~flip_trig;
   endsequence

   a_clock_enable:
      assert property (s_enable_cmd |=> clk_en_r)
      else $error("clock enable command lost");
   a_clock_disable:
      assert property (cmd_wr & w_data_r[`TCCM_CMD_CLK_DIS] |=> ~clk_en_r ##1 ~clk_en_r | cmd_wr)
      else $error("clock disable command lost");
   a_soft_clear:
      assert property (sw_trig & ~updown |=> cnt_r == '0)
      else $error("software trigger did not clear counter");
   a_b_load_stop:
      assert property (~wave & cap.stop_on_b_load & b_load |=> clk_stop_r & ~tick)
      else $error("counter clock not stopped on b load");
   a_b_load_disable:
      assert property (~wave & cap.disable_on_b_load & b_load |=> ~clk_en_r)
      else $error("counter clock not disabled on b load");
   a_c_restart:
      assert property (s_c_restart |=> (cnt_r == '0))
      else $error("c match trigger did not restart counter");
   a_c_stop:
      assert property (wave & wav.stop_on_c_match & c_match |=> ~running)
      else $error("counter clock not stopped on c match");
   a_line_b_input:
      assert property (wave & (wav.event_source_select == 2'h0) |=> io_line_b_oe_n)
      else $error("line b driven while used as event input");
   a_a_toggle:
      assert property (wave & a_match & ~sw_trig & ~evt_hit & ~c_match &
                       (wav.out_a_on_a_match == tccm_pkg::act_toggle)
                       |=> io_line_a_out != $past(io_line_a_out))
      else $error("a match toggle not applied");
   a_top_turn:
      assert property (s_top_turn |=> dir_r & (cnt_r == {CNT_W{1'h1}} - 1'h1))
      else $error("up-down counter did not turn at top");
   a_load_copy:
      assert property (a_load |=> ra_r == $past(cnt_r))
      else $error("register a did not capture counter");
endmodule // tccm_channel

// ==== rtl/tccm_cfg.svh ====
// register offsets, field positions and reset values of the timer channel
`ifndef TCCM_CFG_SVH
`define TCCM_CFG_SVH
`define TCCM_OFS_COMMAND 8'h00
`define TCCM_OFS_MODE 8'h04
`define TCCM_OFS_COUNT 8'h10
`define TCCM_OFS_CMP_A 8'h14
`define TCCM_OFS_CMP_B 8'h18
`define TCCM_OFS_CMP_C 8'h1C
`define TCCM_OFS_STATUS 8'h20
`define TCCM_CMD_CLK_EN 0
`define TCCM_CMD_CLK_DIS 1
`define TCCM_CMD_SW_TRIG 2
`define TCCM_STS_CLK_ON 16
`define TCCM_STS_OUT_A 17
`define TCCM_STS_OUT_B 18
`define TCCM_MODE_RESET 32'h0000_0000
`define TCCM_RESP_OKAY 2'h0
`define TCCM_RESP_SLVERR 2'h2
`endif

// ==== rtl/tccm_pkg.sv ====
// types shared by the timer channel design files
package tccm_pkg;
   typedef enum logic [1:0]
   {
      act_none = 2'h0,
      act_set = 2'h1,
      act_clear = 2'h2,
      act_toggle = 2'h3
   } tccm_action_type;

   // synchronised input: stable level and one-cycle edge pulses
   typedef struct packed
   {
      logic lvl;
      logic rise;
      logic fall;
   } tccm_sig_type;

   typedef struct packed
   {
      logic [11:0] reserved_hi;
      logic [1:0] b_load_edge;
      logic [1:0] a_load_edge;
      logic wave;
      logic c_match_trigger_enable;
      logic [2:0] reserved_mid;
      logic trigger_line_select;
      logic [1:0] trigger_edge_select;
      logic disable_on_b_load;
      logic stop_on_b_load;
      logic [1:0] burst_gate;
      logic clock_invert;
      logic [2:0] clock_source_select;
   } tccm_cap_type;

   typedef struct packed
   {
      logic [1:0] out_b_on_soft_trigger;
      logic [1:0] out_b_on_event;
      logic [1:0] out_b_on_c_match;
      logic [1:0] out_b_on_b_match;
      logic [1:0] out_a_on_soft_trigger;
      logic [1:0] out_a_on_event;
      logic [1:0] out_a_on_c_match;
      logic [1:0] out_a_on_a_match;
      logic wave;
      logic [1:0] waveform_select;
      logic event_trigger_enable;
      logic [1:0] event_source_select;
      logic [1:0] event_edge_select;
      logic disable_on_c_match;
      logic stop_on_c_match;
      logic [1:0] burst_gate;
      logic clock_invert;
      logic [2:0] clock_source_select;
   } tccm_wave_type;
endpackage

// ==== rtl/tccm_pin_sync.sv ====
// three-stage pin synchroniser with filtered level and edge pulses
`timescale 1ns/1ps
module tccm_pin_sync
#(
   parameter int W = 1
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [W-1:0] pin_in,
   output tccm_pkg::tccm_sig_type [W-1:0] sig_out
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   logic [W-1:0] lvl_r;
   logic [W-1:0] rise_r;
   logic [W-1:0] fall_r;
   logic [W-1:0] agree;

   // a change counts only once stages two and three agree
   assign agree = ~(s2_r ^ s3_r);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         lvl_r <= '0;
         rise_r <= '0;
         fall_r <= '0;
      end
      else
      begin
         s1_r <= pin_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         lvl_r <= (agree & s3_r) | (~agree & lvl_r);
         rise_r <= agree & s3_r & ~lvl_r;
         fall_r <= agree & ~s3_r & lvl_r;
      end
   end

   for (genvar gi = 0; gi < W; gi++)
   begin : g_out
      assign sig_out[gi] = '{lvl: lvl_r[gi], rise: rise_r[gi], fall: fall_r[gi]};
   end
endmodule // tccm_pin_sync

// ==== testbench/tccm_far_model.sv ====
// far-side model: timer clock taps, external clocks and both io line wires
`timescale 1ns/1ps
module tccm_far_model
(
   input wire logic aclk,
   input wire logic run,
   input wire logic [2:0] ext_drv,
   input wire logic a_drv,
   input wire logic b_drv,
   input wire logic a_out,
   input wire logic a_oe_n,
   input wire logic b_out,
   input wire logic b_oe_n,
   output logic [4:0] taps,
   output logic [2:0] ext_clk,
   output logic a_in,
   output logic b_in,
   output logic [15:0] n_rise
);
   logic [1:0] div_r = 2'h0;
   logic [4:0] tap_r = 5'h00;
   logic [15:0] rise_r = 16'h0000;
   // ****************
   // tap clocks
   // ****************
   // taps stand still while run is low
   always_ff @(posedge aclk)
   begin
      if (run)
      begin
         div_r <= div_r + 2'h1;
         if (div_r == 2'h3)
         begin
            tap_r <= ~tap_r;
            rise_r <= rise_r + {15'h0000, ~tap_r[0]};
         end
      end
   end
   assign taps = tap_r;
   assign n_rise = rise_r;
   assign ext_clk = ext_drv;
   // a released line shows what the outside world drives
   assign a_in = a_oe_n ? a_drv : a_out;
   assign b_in = b_oe_n ? b_drv : b_out;
endmodule // tccm_far_model

// ==== testbench/tccm_channel_tb_top.sv ====
// self-checking bench for the timer channel
`timescale 1ns/1ps
`include "tccm_cfg.svh"
module tccm_channel_tb_top;
   localparam logic [7:0] MD = `TCCM_OFS_MODE;
   localparam logic [7:0] CM = `TCCM_OFS_COMMAND;
   localparam logic [7:0] CN = `TCCM_OFS_COUNT;
   localparam logic [7:0] ST = `TCCM_OFS_STATUS;
   localparam logic [1:0] OK = `TCCM_RESP_OKAY;
   localparam logic [33:0] CLK_ON = 34'h1 << `TCCM_STS_CLK_ON;
   logic aclk = 1'b0, aresetn = 1'b0, run = 1'b0, a_drv = 1'b0, b_drv = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] wstrb = 4'hf;
   logic [2:0] ext_drv = 3'h0;
   logic awready, wready, bvalid, arready, rvalid, a_out, a_oe_n, b_out, b_oe_n, a_in, b_in;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [4:0] taps;
   logic [2:0] ext_clk;
   logic [15:0] n_rise, base, c;
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   logic [31:0] seed = 32'h0000_b35c;
   logic [1:0] acts[4] = '{2'h1, 2'h2, 2'h3, 2'h3};
   logic [3:0] lv = 4'h5;
   int n_fail = 0, n_checks = 0;
   tccm_pkg::tccm_wave_type wm;
   tccm_pkg::tccm_cap_type cm;
   tccm_channel i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .internal_clock_taps(taps), .ext_clock_in(ext_clk), .io_line_a_in(a_in),
      .io_line_a_out(a_out), .io_line_a_oe_n(a_oe_n), .io_line_b_in(b_in),
      .io_line_b_out(b_out), .io_line_b_oe_n(b_oe_n));
   tccm_far_model i_far (.aclk(aclk), .run(run), .ext_drv(ext_drv), .a_drv(a_drv),
      .b_drv(b_drv), .a_out(a_out), .a_oe_n(a_oe_n), .b_out(b_out), .b_oe_n(b_oe_n),
      .taps(taps), .ext_clk(ext_clk), .a_in(a_in), .b_in(b_in), .n_rise(n_rise));
   initial
   begin
      forever #4 aclk = ~aclk;
   end
   // ****************
   // helpers
   // ****************
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [33:0] got, input logic [33:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic tmo(input logic done);
      if (!done)
      begin
         n_fail++;
         results();
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   // tap clocks run for n cycles, then the counter is left to settle
   task automatic spin(input int n);
      run <= 1'b1;
      cyc(n);
      run <= 1'b0;
      cyc(8);
   endtask
   task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
      logic ta, tw, tb;
      bq.push_back(er);
      awaddr <= ad;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      tb = 1'b0;
      for (int t = 0; t < 100 && !tb; t++)
      begin
         @(negedge aclk);
         ta = awvalid & awready;
         tw = wvalid & wready;
         tb = bvalid;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end
      tmo(tb);
   endtask
   task automatic rd(input logic [7:0] ad, input logic [33:0] e);
      logic ta, tr;
      rq.push_back(e);
      araddr <= ad;
      arvalid <= 1'b1;
      rready <= 1'b1;
      tr = 1'b0;
      for (int t = 0; t < 100 && !tr; t++)
      begin
         @(negedge aclk);
         ta = arvalid & arready;
         tr = rvalid;
         @(posedge aclk);
         if (ta) arvalid <= 1'b0;
      end
      tmo(tr);
   endtask
   // responses are matched against the oldest noted expectation
   always @(posedge aclk)
   begin
      if ((bvalid & bready) === 1'b1) chk("bresp", {32'h0, bresp}, {32'h0, bq.pop_front()});
      if ((rvalid & rready) === 1'b1) chk("rdata", {rresp, rdata}, rq.pop_front());
   end
   // ****************
   // scenarios
   // ****************
   initial
   begin
      cyc(16);
      aresetn <= 1'b1;
      cyc(1);
      rd(MD, {2'h0, `TCCM_MODE_RESET});
      chk("oe_a", {33'h0, a_oe_n}, 34'h1);
      rd(ST, 34'h0);
      rd(CM, 34'h0);
      rd(8'h08, {`TCCM_RESP_SLVERR, 32'h0});
      wr(8'h0C, 32'h1, `TCCM_RESP_SLVERR);
      seed = xs(seed);
      ext_drv <= seed[2:0];
      wr(`TCCM_OFS_CMP_C, seed, OK);
      rd(`TCCM_OFS_CMP_C, {18'h0, seed[15:0]});
      wr(CM, 32'h1, OK);
      rd(ST, CLK_ON);
      spin(40);
      rd(CN, {18'h0, n_rise});
      wr(CM, 32'h2, OK);
      rd(ST, 34'h0);
      c = n_rise;
      spin(40);
      rd(CN, {18'h0, c});
      wr(CM, 32'h3, OK);
      rd(ST, 34'h0);
      wr(CM, 32'h0, OK);
      rd(ST, 34'h0);
      wr(CM, 32'h1, OK);
      spin(40);
      wr(CM, 32'h4, OK);
      rd(CN, 34'h0);
      base = n_rise;
      spin(40);
      rd(CN, {18'h0, n_rise - base});
      cm = '0;
      cm.a_load_edge = 2'h1;
      wr(MD, cm, OK);
      a_drv <= 1'b1;
      cyc(8);
      rd(`TCCM_OFS_CMP_A, {18'h0, n_rise - base});
      wm = '0;
      wm.wave = 1'b1;
      wm.event_source_select = 2'h1;
      for (int i = 0; i < 4; i++)
      begin
         wm.out_a_on_soft_trigger = acts[i];
         wm.out_b_on_soft_trigger = acts[i];
         wr(MD, wm, OK);
         wr(CM, 32'h4, OK);
         cyc(2);
         chk("line_a", {33'h0, a_out}, {33'h0, lv[i]});
         chk("line_b", {33'h0, b_out}, {33'h0, lv[i]});
         chk("oe_a", {33'h0, a_oe_n}, 34'h0);
         chk("oe_b", {33'h0, b_oe_n}, 34'h0);
      end
      rd(MD, {2'h0, wm});
      wm.event_source_select = 2'h0;
      wm.event_edge_select = 2'h1;
      wm.event_trigger_enable = 1'b1;
      wm.out_a_on_event = 2'h3;
      wm.out_a_on_soft_trigger = 2'h0;
      wr(MD, wm, OK);
      cyc(2);
      chk("oe_b", {33'h0, b_oe_n}, 34'h1);
      spin(40);
      b_drv <= 1'b1;
      cyc(8);
      base = n_rise;
      rd(CN, 34'h0);
      chk("line_a", {33'h0, a_out}, 34'h1);
      b_drv <= 1'b0;
      cyc(8);
      chk("line_a", {33'h0, a_out}, 34'h1);
      wm.event_trigger_enable = 1'b0;
      wr(MD, wm, OK);
      spin(40);
      b_drv <= 1'b1;
      cyc(8);
      rd(CN, {18'h0, n_rise - base});
      chk("line_a", {33'h0, a_out}, 34'h0);
      results();
   end
endmodule // tccm_channel_tb_top
